// [rtl/ext_io_continuous_judgment.sv]
// External control port in continuous measurement mode: trigger edge
// detect, verdict/pass/error outputs and the two end-of-phase strobes.
// Assumes the measuring core gives one-cycle done pulses and results
// valid with its measurement-done pulse; trigger is synchronous.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Measurement starts on a trigger edge
// - Setting selects rising or falling trigger edge
// - Error low if any fault present at measurement done
// - Twelve active-low verdict lines, two panels
// - At most one matching line low per group
// - Pass low when all IN, bins matched
// - Complete strobe falls with verdicts final
// - Conversion-done falls when conversion finishes
module ext_io_continuous_judgment
(
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic                            trigIn,
  input  wire logic                            trigFalling,
  output logic                                 measStart,
  input  wire logic                            convDone,
  input  wire logic                            measDone,
  input  wire logic [2*ext_io_pkg::GROUPS-1:0] verdictCode,
  input  wire logic [ext_io_pkg::GROUPS-1:0]   groupActive,
  input  wire logic                            no_bin_match,
  input  wire logic [ext_io_pkg::FAULTS-1:0]   faults,
  output logic                                 errN,
  output logic                                 allPassN,
  output logic                                 measCompleteN,
  output logic                                 convDoneN,
  output logic                                 panel_a_p1_high,
  output logic                                 panel_a_p1_low,
  output logic                                 panel_a_p1_pass,
  output logic                                 panel_a_p3_high,
  output logic                                 panel_a_p3_low,
  output logic                                 panel_a_p3_pass,
  output logic                                 panel_b_p1_high,
  output logic                                 panel_b_p1_low,
  output logic                                 panel_b_p1_pass,
  output logic                                 panel_b_p3_high,
  output logic                                 panel_b_p3_low,
  output logic                                 panel_b_p3_pass
);
  import ext_io_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } phase_t;

  phase_t                 phase_q, phase_d;
  logic                   trigPrev_q, trigPrev_d;
  logic                   measStart_q, measStart_d;
  logic [2*GROUPS-1:0]    code_q, code_d;
  logic                   errN_q, errN_d;
  logic                   allPassN_q, allPassN_d;
  logic                   eomN_q, eomN_d;
  logic                   idxN_q, idxN_d;
  logic [STROBE_CW-1:0]   eomCnt_q, eomCnt_d;
  logic [STROBE_CW-1:0]   idxCnt_q, idxCnt_d;
  logic                   validEdge;
  logic                   allIn;
  logic [3*GROUPS-1:0]    lineN_q, lineN_d;

  // Edge chosen by the setting; a level starts a run only if high at reset release with the rising setting
  assign validEdge = trigFalling ? (trigPrev_q & ~trigIn)
                                 : (~trigPrev_q & trigIn);

  always_comb
  begin
    allIn = 1'b1;
    for (int g = 0; g < GROUPS; g++)
    begin
      if (groupActive[g] && verdictCode[2*g +: 2] != VERDICT_PASS)
      begin
        allIn = 1'b0;
      end
    end
  end

  always_comb
  begin
    phase_d     = phase_q;
    trigPrev_d  = trigIn;
    measStart_d = 1'b0;
    code_d      = code_q;
    errN_d      = errN_q;
    allPassN_d  = allPassN_q;
    eomN_d      = eomN_q;
    idxN_d      = idxN_q;
    eomCnt_d    = eomCnt_q;
    idxCnt_d    = idxCnt_q;
    // A new run may start while a strobe is still low
    // Strobes return high after their width
    if (idxCnt_q != '0)
    begin
      idxCnt_d = idxCnt_q - 1'b1;
      if (idxCnt_q == 1)
      begin
        idxN_d = 1'b1;
      end
    end
    if (eomCnt_q != '0)
    begin
      eomCnt_d = eomCnt_q - 1'b1;
      if (eomCnt_q == 1)
      begin
        eomN_d = 1'b1;
      end
    end
    unique case (phase_q)
      // Only an edge in the chosen direction starts a run
      ST_IDLE:
      begin
        if (validEdge)
        begin
          measStart_d = 1'b1;
          phase_d     = ST_CONV;
        end
      end
      // Trigger edges are ignored until the results are out
      ST_CONV:
      begin
        if (convDone)
        begin
          idxN_d   = 1'b0;
          idxCnt_d = STROBE_LEN;
          phase_d  = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // Results latch with the complete strobe, never before it
        if (measDone)
        begin
          for (int g = 0; g < GROUPS; g++)
          begin
            code_d[2*g +: 2] = groupActive[g]
                             ? verdictCode[2*g +: 2]
                             : VERDICT_NONE;
          end
          allPassN_d = ~(allIn & ~no_bin_match);
          errN_d     = ~(|faults);
          eomN_d     = 1'b0;
          eomCnt_d   = STROBE_LEN;
          phase_d    = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    // Every active-low pin idles high, and measStart low, while reset is held
    if (reset)
    begin
      phase_q     <= ST_IDLE;
      trigPrev_q  <= 1'b0;
      measStart_q <= 1'b0;
      code_q      <= '0;
      errN_q      <= 1'b1;
      allPassN_q  <= 1'b1;
      eomN_q      <= 1'b1;
      idxN_q      <= 1'b1;
      eomCnt_q    <= '0;
      idxCnt_q    <= '0;
      lineN_q     <= '1;
    end
    else
    begin
      phase_q     <= phase_d;
      trigPrev_q  <= trigPrev_d;
      measStart_q <= measStart_d;
      code_q      <= code_d;
      errN_q      <= errN_d;
      allPassN_q  <= allPassN_d;
      eomN_q      <= eomN_d;
      idxN_q      <= idxN_d;
      eomCnt_q    <= eomCnt_d;
      idxCnt_q    <= idxCnt_d;
      lineN_q     <= lineN_d;
    end
  end

  // One decoder per verdict group
  // Decoding the next code lets the lines leave flops with the strobe
  for (genvar g = 0; g < GROUPS; g++)
  begin : gDec
    verdict_decode uDec (
      .code  (code_d[2*g +: 2]),
      .highN (lineN_d[3*g]),
      .lowN  (lineN_d[3*g+1]),
      .passN (lineN_d[3*g+2])
    );
  end

  assign measStart       = measStart_q;
  assign errN            = errN_q;
  assign allPassN        = allPassN_q;
  assign measCompleteN   = eomN_q;
  assign convDoneN       = idxN_q;
  assign panel_a_p1_high = lineN_q[3*GRP_A_P1];
  assign panel_a_p1_low  = lineN_q[3*GRP_A_P1+1];
  assign panel_a_p1_pass = lineN_q[3*GRP_A_P1+2];
  assign panel_a_p3_high = lineN_q[3*GRP_A_P3];
  assign panel_a_p3_low  = lineN_q[3*GRP_A_P3+1];
  assign panel_a_p3_pass = lineN_q[3*GRP_A_P3+2];
  assign panel_b_p1_high = lineN_q[3*GRP_B_P1];
  assign panel_b_p1_low  = lineN_q[3*GRP_B_P1+1];
  assign panel_b_p1_pass = lineN_q[3*GRP_B_P1+2];
  assign panel_b_p3_high = lineN_q[3*GRP_B_P3];
  assign panel_b_p3_low  = lineN_q[3*GRP_B_P3+1];
  assign panel_b_p3_pass = lineN_q[3*GRP_B_P3+2];
endmodule
`default_nettype wire

// [rtl/ext_io_pkg.sv]
// Constants for the continuous-mode external control port.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package ext_io_pkg;
  localparam int CLK_HZ          = 10_000_000;
  // Width of the end-of-conversion and end-of-measurement strobes, in us
  localparam int STROBE_US       = 1;
  localparam int STROBE_CYC_RAW  = (STROBE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int STROBE_CYC      = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
  localparam int STROBE_CW       = 8;
  localparam logic [STROBE_CW-1:0] STROBE_LEN = STROBE_CW'(STROBE_CYC);
  // Verdict codes from the measuring core
  localparam logic [1:0] VERDICT_NONE = 2'h0;
  localparam logic [1:0] VERDICT_HIGH = 2'h1;
  localparam logic [1:0] VERDICT_LOW  = 2'h2;
  localparam logic [1:0] VERDICT_PASS = 2'h3;
  // Number of verdict groups: two panels by parameters 1 and 3
  localparam int GROUPS          = 4;
  localparam int GRP_A_P1        = 0;
  localparam int GRP_A_P3        = 1;
  localparam int GRP_B_P1        = 2;
  localparam int GRP_B_P3        = 3;
  // Fault vector bit positions
  localparam int FAULTS          = 7;
  localparam int FLT_SAMPLING    = 0;
  localparam int FLT_OVERCURRENT = 1;
  localparam int FLT_CONTACT     = 2;
  localparam int FLT_HIGHZ       = 3;
  localparam int FLT_TEMP        = 4;
  localparam int FLT_CONST_VI    = 5;
  localparam int FLT_LIMIT       = 6;
endpackage

// [rtl/verdict_decode.sv]
// Decodes one verdict code into three active-low verdict lines.
// Assumes the caller gives its next code and registers the decoded lines.
`timescale 1ns/1ns
`default_nettype none
module verdict_decode
(
  input  wire logic [1:0] code,
  output logic            highN,
  output logic            lowN,
  output logic            passN
);
  import ext_io_pkg::*;
  // At most one line low per group; none when the group is inactive
  always_comb
  begin
    highN = ~(code == VERDICT_HIGH);
    lowN  = ~(code == VERDICT_LOW);
    passN = ~(code == VERDICT_PASS);
  end
endmodule
`default_nettype wire

// [tb/ext_io_chk.sv]
// Assertions on the continuous-mode port outputs.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module ext_io_chk
(
  input wire logic                            clk,
  input wire logic                            reset,
  input wire logic                            trigIn,
  input wire logic                            trigFalling,
  input wire logic                            measStart,
  input wire logic                            convDone,
  input wire logic                            measDone,
  input wire logic [2*ext_io_pkg::GROUPS-1:0] verdictCode,
  input wire logic [ext_io_pkg::GROUPS-1:0]   groupActive,
  input wire logic                            no_bin_match,
  input wire logic [ext_io_pkg::FAULTS-1:0]   faults,
  input wire logic                            errN,
  input wire logic                            allPassN,
  input wire logic                            measCompleteN,
  input wire logic                            convDoneN
);
  import ext_io_pkg::*;
  logic allIn;
  always_comb
  begin
    allIn = !no_bin_match;
    for (int g = 0; g < GROUPS; g++)
      if (groupActive[g] && verdictCode[2*g+:2] != VERDICT_PASS)
        allIn = 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_start;
    measStart |-> $past(trigIn) != $past(trigIn, 2)
      && $past(trigIn) != $past(trigFalling);
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_conv; $fell(convDoneN) |-> $past(convDone); endproperty
  a_conv: assert property (p_conv) else $error("bad conv");
  property p_convLen;
    $fell(convDoneN) |=> !convDoneN[*8] ##1 !convDoneN ##1 convDoneN;
  endproperty
  a_convLen: assert property (p_convLen) else $error("conv len");
  property p_eom; $fell(measCompleteN) |-> $past(measDone); endproperty
  a_eom: assert property (p_eom) else $error("bad eom");
  property p_eomLen;
    $fell(measCompleteN) |=> !measCompleteN[*8] ##1 !measCompleteN
      ##1 measCompleteN;
  endproperty
  a_eomLen: assert property (p_eomLen) else $error("eom len");
  property p_err;
    $fell(measCompleteN) |-> errN == !(|$past(faults));
  endproperty
  a_err: assert property (p_err) else $error("bad err");
  property p_pass; $fell(measCompleteN) |-> allPassN == !$past(allIn);
  endproperty
  a_pass: assert property (p_pass) else $error("bad pass");
  property p_hold;
    !$fell(measCompleteN) |-> $stable(errN) && $stable(allPassN);
  endproperty
  a_hold: assert property (p_hold) else $error("not held");
endmodule
`default_nettype wire

// [tb/handler_model.sv]
// External handler: makes one valid trigger edge per go pulse.
// Idles at the inactive level so only go yields a valid edge.
`timescale 1ns/1ns
`default_nettype none
module handler_model (
  input wire logic clk,
  input wire logic go,
  input wire logic falling,
  output logic     trigIn
);
  initial trigIn = 1'b0;
  always @(posedge clk)
    trigIn <= go ? !falling : falling;
endmodule
`default_nettype wire

// [tb/tb.sv]
// Bench: drives core events, queues expected results, scores them.
// Uses handler_model on the trigger and binds ext_io_chk.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) \
  compares++; \
  if ((got) !== (ex)) \
  begin \
    n_errors++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); \
  end
module tb;
  import ext_io_pkg::*;
  logic       clk = 1'b0;
  logic       reset, trigIn, trigFalling, measStart, convDone, measDone;
  logic       go, no_bin_match, errN, allPassN, measCompleteN, convDoneN;
  logic       mcPrev = 1'b0;
  logic [7:0] verdictCode;
  logic [3:0] groupActive;
  logic [6:0] faults;
  logic       panel_a_p1_high, panel_a_p1_low, panel_a_p1_pass;
  logic       panel_a_p3_high, panel_a_p3_low, panel_a_p3_pass;
  logic       panel_b_p1_high, panel_b_p1_low, panel_b_p1_pass;
  logic       panel_b_p3_high, panel_b_p3_low, panel_b_p3_pass;
  logic [13:0] e;
  logic [13:0] r;
  logic [13:0] expQ[$];
  int n_errors = 0, compares = 0, starts = 0, nMeas = 0, k;
  ext_io_continuous_judgment u_dut (
    .clk             (clk),
    .reset           (reset),
    .trigIn          (trigIn),
    .trigFalling     (trigFalling),
    .measStart       (measStart),
    .convDone        (convDone),
    .measDone        (measDone),
    .verdictCode     (verdictCode),
    .groupActive     (groupActive),
    .no_bin_match    (no_bin_match),
    .faults          (faults),
    .errN            (errN),
    .allPassN        (allPassN),
    .measCompleteN   (measCompleteN),
    .convDoneN       (convDoneN),
    .panel_a_p1_high (panel_a_p1_high),
    .panel_a_p1_low  (panel_a_p1_low),
    .panel_a_p1_pass (panel_a_p1_pass),
    .panel_a_p3_high (panel_a_p3_high),
    .panel_a_p3_low  (panel_a_p3_low),
    .panel_a_p3_pass (panel_a_p3_pass),
    .panel_b_p1_high (panel_b_p1_high),
    .panel_b_p1_low  (panel_b_p1_low),
    .panel_b_p1_pass (panel_b_p1_pass),
    .panel_b_p3_high (panel_b_p3_high),
    .panel_b_p3_low  (panel_b_p3_low),
    .panel_b_p3_pass (panel_b_p3_pass)
  );
  handler_model u_hdl (.clk(clk), .go(go), .falling(trigFalling),
    .trigIn(trigIn));
  initial forever #50 clk = ~clk;
  function automatic logic [13:0] expv(logic [7:0] vc, logic [3:0] ga,
    logic nb, logic [6:0] fl);
    logic [11:0] l;
    logic p;
    p = !nb;
    for (int g = 0; g < 4; g++)
    begin
      l[11-3*g -: 3] = {!(ga[g] && vc[2*g+:2] == VERDICT_HIGH),
        !(ga[g] && vc[2*g+:2] == VERDICT_LOW),
        !(ga[g] && vc[2*g+:2] == VERDICT_PASS)};
      if (ga[g] && vc[2*g+:2] != VERDICT_PASS) p = 1'b0;
    end
    return {!(|fl), !p, l};
  endfunction
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic meas(logic f, logic [6:0] flt, logic allIn);
    logic [7:0] vc;
    logic [3:0] ga;
    logic nb;
    vc = allIn ? 8'hff : 8'($urandom);
    ga = 4'($urandom);
    nb = allIn ? 1'b0 : ($urandom % 4 == 0);
    trigFalling <= f;
    repeat (2) @(posedge clk);
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    k = 0;
    while (measStart !== 1'b1 && k < 8)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 8)
    begin
      n_errors++;
      test_done();
    end
    else
    begin
      go <= 1'b1;
      measDone <= 1'b1;
      @(posedge clk) go <= 1'b0;
      measDone <= 1'b0;
      convDone <= 1'b1;
      @(posedge clk) convDone <= 1'b0;
      measDone <= 1'b1;
      {verdictCode, groupActive, no_bin_match, faults} <= {vc, ga, nb, flt};
      expQ.push_back(expv(vc, ga, nb, flt));
      nMeas++;
      @(posedge clk) measDone <= 1'b0;
      verdictCode <= 8'($urandom);
      repeat (14) @(posedge clk);
    end
  endtask
  always @(posedge clk)
  begin
    if (measStart === 1'b1) starts++;
    if (mcPrev === 1'b1 && measCompleteN === 1'b0)
    begin
      e = expQ.size() == 0 ? 14'h0 : expQ.pop_front();
      r = {errN, allPassN, panel_a_p1_high, panel_a_p1_low, panel_a_p1_pass,
        panel_a_p3_high, panel_a_p3_low, panel_a_p3_pass, panel_b_p1_high,
        panel_b_p1_low, panel_b_p1_pass, panel_b_p3_high, panel_b_p3_low,
        panel_b_p3_pass};
      `CHK("results", e, r)
    end
    mcPrev <= measCompleteN;
  end
  initial
  begin
    {reset, trigFalling, convDone, measDone, go} = 5'h10;
    {verdictCode, groupActive, no_bin_match, faults} = 20'h0;
    void'($urandom(32'hd4454883));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < FAULTS; i++)
      meas(i[0], 7'(1) << i, 1'b0);
    meas(1'b0, 7'h0, 1'b1);
    meas(1'b1, 7'h0, 1'b1);
    for (int i = 0; i < 16; i++)
      meas(1'($urandom), ($urandom % 2) ? 7'($urandom) : 7'h0, 1'b0);
    `CHK("starts", nMeas, starts)
    `CHK("pending", 0, expQ.size())
    test_done();
  end
endmodule
bind ext_io_continuous_judgment ext_io_chk u_chk (
  .clk           (clk),
  .reset         (reset),
  .trigIn        (trigIn),
  .trigFalling   (trigFalling),
  .measStart     (measStart),
  .convDone      (convDone),
  .measDone      (measDone),
  .verdictCode   (verdictCode),
  .groupActive   (groupActive),
  .no_bin_match  (no_bin_match),
  .faults        (faults),
  .errN          (errN),
  .allPassN      (allPassN),
  .measCompleteN (measCompleteN),
  .convDoneN     (convDoneN)
);
`default_nettype wire
